// ===== rtl/vlms_defines.svh
// Constants for the output-voltage limit, margin and slew register bank
`ifndef VLMS_DEFINES_SVH
`define VLMS_DEFINES_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define VLMS_CMD_UPPER_LIMIT 8'h24
`define VLMS_CMD_MARGIN_HIGH 8'h25
`define VLMS_CMD_MARGIN_LOW 8'h26
`define VLMS_CMD_SLEW_RATE 8'h27

// ----------------------------------------------------------------------
// Slew rate word layout and reset
// ----------------------------------------------------------------------
`define VLMS_SLEW_EXP_MSB 15
`define VLMS_SLEW_EXP_LSB 11
`define VLMS_SLEW_MAN_MSB 10
`define VLMS_SLEW_MAN_LSB 0
`define VLMS_SLEW_EXP_RST 5'h1c

// ----------------------------------------------------------------------
// Voltage exponent span and absolute scale (LSB of 2^-12 V)
// ----------------------------------------------------------------------
`define VLMS_VEXP_MIN (-12)
`define VLMS_VEXP_MAX (-4)
`define VLMS_ABS_W 26
`define VLMS_FRAC_W 16

// ----------------------------------------------------------------------
// Slew rate span, in thousandths of mV/us, and in 2^-8 mV/us units
// ----------------------------------------------------------------------
`define VLMS_RATE_MIN_MILLI 67
`define VLMS_RATE_MAX_MILLI 15933
`define VLMS_RATE_MIN_Q8 ((`VLMS_RATE_MIN_MILLI * 256 + 999) / 1000)
`define VLMS_RATE_MAX_Q8 ((`VLMS_RATE_MAX_MILLI * 256) / 1000)
`define VLMS_RATE_CODE_MIN 1
`define VLMS_RATE_CODE_MAX 255

// ----------------------------------------------------------------------
// Timing: one rate code (1/16 mV/us) per clock, in 2^-16 absolute LSB
// ----------------------------------------------------------------------
`define VLMS_CLK_PERIOD_NS 20
`define VLMS_STEP_PER_CODE ((`VLMS_CLK_PERIOD_NS * (1 << 24) + 500000) / 1000000)

`endif

// ===== rtl/vlms_pkg.sv
// Types and decoding functions for the limit, margin and slew bank
package vlms_pkg;
	`include "vlms_defines.svh"

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		VLMS_MARGIN_OFF = 2'h0,
		VLMS_MARGIN_LOW = 2'h1,
		VLMS_MARGIN_HIGH = 2'h2,
		VLMS_MARGIN_RSVD = 2'h3
	} vlms_margin_t;

	typedef logic signed [`VLMS_ABS_W-1:0] vlms_abs_t;

	// ------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------
	// Unsupported exponents saturate to the nearest end of the span
	function automatic logic [3:0] vlms_vshift(input logic [4:0] e);
		logic signed [5:0] s;
		s = $signed({e[4], e});
		if (s < 6'(`VLMS_VEXP_MIN))
			s = 6'(`VLMS_VEXP_MIN);
		if (s > 6'(`VLMS_VEXP_MAX))
			s = 6'(`VLMS_VEXP_MAX);
		return 4'(s - 6'(`VLMS_VEXP_MIN));
	endfunction

	function automatic vlms_abs_t vlms_to_abs(input logic [15:0] w, input logic [3:0] sh,
			input logic sgn);
		vlms_abs_t x;
		x = sgn ? {{(`VLMS_ABS_W-16){w[15]}}, w} : {{(`VLMS_ABS_W-16){1'b0}}, w};
		return x <<< sh;
	endfunction

	// Rate word to 2^-8 mV/us; saturates rather than wrapping
	function automatic logic signed [31:0] vlms_rate_q8(input logic [15:0] w);
		logic signed [31:0] m;
		logic signed [6:0] e;
		m = {{21{w[`VLMS_SLEW_MAN_MSB]}}, w[`VLMS_SLEW_MAN_MSB:`VLMS_SLEW_MAN_LSB]};
		e = $signed({{2{w[`VLMS_SLEW_EXP_MSB]}}, w[`VLMS_SLEW_EXP_MSB:`VLMS_SLEW_EXP_LSB]})
			+ 7'sd8;
		if (e > 7'sd15)
			return m[31] ? 32'sh8000_0000 : 32'sh7fff_ffff;
		else if (e >= 7'sd0)
			return m <<< e[3:0];
		else
			return m >>> 5'(-e);
	endfunction
endpackage

// ===== rtl/vlms_ramp_if.sv
// Carrier between the register bank and its slew engine
`timescale 1ns/1ps
`include "vlms_defines.svh"
interface vlms_ramp_if;
	logic signed [`VLMS_ABS_W-1:0] target;
	logic [31:0] step;
	logic bypass;
	logic signed [`VLMS_ABS_W-1:0] vref;
	logic settled;

	modport bank(output target, output step, output bypass, input vref, input settled);
	modport ramp(input target, input step, input bypass, output vref, output settled);
endinterface

// ===== rtl/vlms_ramp.sv
// Slew engine moving the reference toward its target at a fixed step
`timescale 1ns/1ps
`include "vlms_defines.svh"
module vlms_ramp
	import vlms_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	vlms_ramp_if.ramp rif
);
	localparam int ACC_W = `VLMS_ABS_W + `VLMS_FRAC_W;

	logic signed [ACC_W-1:0] acc_q;
	logic signed [ACC_W-1:0] acc_d;
	logic signed [ACC_W-1:0] goal;
	logic signed [ACC_W-1:0] diff;
	logic signed [ACC_W-1:0] step_w;

	always_comb begin
		goal = {rif.target, {`VLMS_FRAC_W{1'b0}}};
		step_w = $signed({{(ACC_W-32){1'b0}}, rif.step});
		diff = goal - acc_q;
		if (rif.bypass)
			acc_d = goal;
		else if (diff > step_w)
			acc_d = acc_q + step_w;
		else if (diff < -step_w)
			acc_d = acc_q - step_w;
		else
			acc_d = goal;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			acc_q <= '0;
		else if (ce)
			acc_q <= acc_d;
	end

	assign rif.vref = acc_q[ACC_W-1:`VLMS_FRAC_W];
	assign rif.settled = (acc_q == goal);
endmodule

// ===== rtl/vlms_status.sv
// Sticky status flags and the shared active-low alert
`timescale 1ns/1ps
module vlms_status #(
	parameter int N = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [N-1:0] set,
	input wire logic clear,
	output logic [N-1:0] flags,
	output logic alert_n
);
	logic [N-1:0] flag_q;
	logic [N-1:0] flag_d;
	logic alert_n_q;

	// Set beats clear so an event in the clearing cycle survives
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			always_comb begin
				flag_d[i] = set[i] | (flag_q[i] & ~clear);
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_q <= '0;
			alert_n_q <= 1'b1;
		end else if (ce) begin
			flag_q <= flag_d;
			alert_n_q <= ~(|flag_d);
		end
	end

	assign flags = flag_q;
	assign alert_n = alert_n_q;
endmodule

// ===== rtl/vlms_top.sv
// Output-voltage upper limit, margin targets and slew rate register bank
`timescale 1ns/1ps
`include "vlms_defines.svh"

// Summary of operation
// [RULE_01] Upper limit word at 24h, read/write, unsigned absolute, applied at once.
// [RULE_02] Upper limit default loads from storage or pin detection at power-up.
// [RULE_03] While converting, a target above the limit is replaced by the limit.
// [RULE_04] Clamping sets none-above, word VOUT, max/min warning, and raises alert.
// [RULE_05] Lowering the limit below the present target clamps and warns likewise.
// [RULE_06] Margin-high word at 25h, relative or absolute, default from storage.
// [RULE_07] Margin-low word at 26h, relative or absolute, default from storage.
// [RULE_08] Margin selection sets target to that margin value plus trim.
// [RULE_09] Output moves toward a margin target at the programmed slew rate.
// [RULE_10] Margin-high plus trim is checked against the upper limit.
// [RULE_11] Out-of-range margin or rate writes flag invalid data and alert.
// [RULE_12] Slew rate word at 27h, linear format, mV/us, default from storage.
// [RULE_13] Slew rate applies only in normal conversion, not on/off ramps.
// [RULE_14] Rate exponent bits 15:11 reset 11100b; mantissa bits 10:0.
// [RULE_15] Rate word reads back as written; slew uses nearest supported rate.
// [RULE_16] Supported rates span 0.067 to 15.933 mV/us; host stays inside.
// [RULE_17] Voltage words use the format exponent, from -4 down to -12.
// [RULE_18] Targets and limit compare in one absolute scale after decoding.
module vlms_top
	import vlms_pkg::*;
#(
	parameter vlms_abs_t VALID_MAX_ABS = 26'sd24576
) (
	// ------------------------------------------------------------------
	// Clock, reset and command port
	// ------------------------------------------------------------------
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic cmd_ack,
	output logic cmd_nack,
	output logic [15:0] cmd_rdata,
	// ------------------------------------------------------------------
	// Voltage format and operating state
	// ------------------------------------------------------------------
	input wire logic [4:0] vout_exp,
	input wire logic vout_relative,
	input wire logic [15:0] nominal_cmd,
	input wire logic [15:0] trim_cmd,
	input wire logic [1:0] margin_sel,
	input wire logic conv_en,
	input wire logic onoff_ramp,
	// ------------------------------------------------------------------
	// Power-up, restore defaults and status clear
	// ------------------------------------------------------------------
	input wire logic [15:0] nvm_upper_limit,
	input wire logic [15:0] pin_upper_limit,
	input wire logic limit_from_pin,
	input wire logic [15:0] nvm_margin_high,
	input wire logic [15:0] nvm_margin_low,
	input wire logic [10:0] nvm_slew_mantissa,
	input wire logic restore_defaults,
	input wire logic status_clear,
	// ------------------------------------------------------------------
	// Reference, status and alert
	// ------------------------------------------------------------------
	output logic [25:0] target_abs,
	output logic [25:0] vref_abs,
	output logic vref_settled,
	output logic status_none_above,
	output logic status_word_vout,
	output logic status_vout_maxmin,
	output logic status_cml_invalid,
	output logic alert_n
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [15:0] limit_q, limit_d;
	logic [15:0] mhigh_q, mhigh_d;
	logic [15:0] mlow_q, mlow_d;
	logic [15:0] rate_q, rate_d;
	logic boot_q, boot_d;
	logic clamp_q, clamp_d;
	logic ack_q, ack_d;
	logic nack_q, nack_d;
	logic [15:0] rdata_q, rdata_d;
	logic [25:0] target_q, target_d;

	// ------------------------------------------------------------------
	// Decoding into the common absolute scale
	// ------------------------------------------------------------------
	logic [3:0] vsh;
	vlms_abs_t nom_abs;
	vlms_abs_t trim_abs;
	vlms_abs_t limit_abs;
	vlms_abs_t base_abs;
	vlms_abs_t cand_abs;
	logic over;
	vlms_margin_t msel;

	// Relative margins resolve against the nominal before any compare
	function automatic vlms_abs_t margin_abs(input logic [15:0] w, input logic [3:0] sh,
			input logic rel, input vlms_abs_t nom);
		vlms_abs_t m;
		m = vlms_to_abs(w, sh, 1'b0);
		return rel ? nom + m : m;
	endfunction

	function automatic logic is_mapped(input logic [7:0] c);
		return c == `VLMS_CMD_UPPER_LIMIT || c == `VLMS_CMD_MARGIN_HIGH ||
			c == `VLMS_CMD_MARGIN_LOW || c == `VLMS_CMD_SLEW_RATE;
	endfunction

	always_comb begin
		vsh = vlms_vshift(vout_exp); // [RULE_17]
		nom_abs = vlms_to_abs(nominal_cmd, vsh, 1'b0);
		trim_abs = vlms_to_abs(trim_cmd, vsh, 1'b1);
		limit_abs = vlms_to_abs(limit_q, vsh, 1'b0); // [RULE_01]
		msel = vlms_margin_t'(margin_sel);
		unique case (msel)
			VLMS_MARGIN_HIGH: base_abs = margin_abs(mhigh_q, vsh, vout_relative, nom_abs); // [RULE_08]
			VLMS_MARGIN_LOW: base_abs = margin_abs(mlow_q, vsh, vout_relative, nom_abs); // [RULE_08]
			VLMS_MARGIN_OFF: base_abs = nom_abs;
			VLMS_MARGIN_RSVD: base_abs = nom_abs;
		endcase
		cand_abs = base_abs + trim_abs; // [RULE_08]
		// A trim that drives the sum negative floors at zero instead of wrapping
		if (cand_abs < 0)
			cand_abs = '0;
		over = cand_abs > limit_abs; // [RULE_10] [RULE_18]
	end

	// ------------------------------------------------------------------
	// Slew rate: exact storage, nearest supported step for the engine
	// ------------------------------------------------------------------
	logic signed [31:0] rate_cur_q8;
	logic signed [31:0] rate_new_q8;
	logic signed [31:0] rate_code;
	logic [31:0] step;
	logic rate_wr_ok;

	always_comb begin
		rate_cur_q8 = vlms_rate_q8(rate_q);
		// Round to the nearest 1/16 mV/us, then hold inside the span
		rate_code = (rate_cur_q8 >>> 4) + 32'(rate_cur_q8[3]); // [RULE_15]
		if (rate_code < `VLMS_RATE_CODE_MIN)
			rate_code = `VLMS_RATE_CODE_MIN;
		if (rate_code > `VLMS_RATE_CODE_MAX)
			rate_code = `VLMS_RATE_CODE_MAX; // [RULE_16]
		step = 32'(rate_code) * 32'(`VLMS_STEP_PER_CODE);
		// A write below the supported span is refused, not rounded up
		rate_new_q8 = vlms_rate_q8(cmd_wdata);
		rate_wr_ok = rate_new_q8 >= `VLMS_RATE_MIN_Q8 && rate_new_q8 <= `VLMS_RATE_MAX_Q8; // [RULE_16]
	end

	// ------------------------------------------------------------------
	// Command handling
	// ------------------------------------------------------------------
	logic wr;
	logic rd;
	logic margin_wr_ok;
	vlms_abs_t margin_new;
	logic invalid_evt;
	logic warn_evt;

	always_comb begin
		wr = cmd_valid && cmd_write;
		rd = cmd_valid && !cmd_write;
		margin_new = margin_abs(cmd_wdata, vsh, vout_relative, nom_abs) + trim_abs;
		// The DAC span bounds a margin word plus trim to 0 through VALID_MAX_ABS
		margin_wr_ok = margin_new >= 0 && margin_new <= VALID_MAX_ABS;
		invalid_evt = wr && (((cmd_code == `VLMS_CMD_MARGIN_HIGH ||
			cmd_code == `VLMS_CMD_MARGIN_LOW) && !margin_wr_ok) ||
			(cmd_code == `VLMS_CMD_SLEW_RATE && !rate_wr_ok)); // [RULE_11]

		// Refused writes are still acknowledged but leave the register as it was
		limit_d = limit_q;
		mhigh_d = mhigh_q;
		mlow_d = mlow_q;
		rate_d = rate_q;
		boot_d = 1'b1;
		// A restore in the same cycle as a write wins over the write
		if (!boot_q || restore_defaults) begin
			limit_d = limit_from_pin ? pin_upper_limit : nvm_upper_limit; // [RULE_02]
			mhigh_d = nvm_margin_high; // [RULE_06]
			mlow_d = nvm_margin_low; // [RULE_07]
			rate_d = {`VLMS_SLEW_EXP_RST, nvm_slew_mantissa}; // [RULE_12] [RULE_14]
		end else if (wr && !invalid_evt) begin
			if (cmd_code == `VLMS_CMD_UPPER_LIMIT)
				limit_d = cmd_wdata; // [RULE_01]
			if (cmd_code == `VLMS_CMD_MARGIN_HIGH)
				mhigh_d = cmd_wdata; // [RULE_06]
			if (cmd_code == `VLMS_CMD_MARGIN_LOW)
				mlow_d = cmd_wdata; // [RULE_07]
			if (cmd_code == `VLMS_CMD_SLEW_RATE)
				rate_d = cmd_wdata; // [RULE_12] [RULE_15]
		end

		ack_d = cmd_valid && is_mapped(cmd_code);
		nack_d = cmd_valid && !is_mapped(cmd_code);
		rdata_d = rdata_q;
		if (rd) begin
			unique case (cmd_code)
				`VLMS_CMD_UPPER_LIMIT: rdata_d = limit_q;
				`VLMS_CMD_MARGIN_HIGH: rdata_d = mhigh_q;
				`VLMS_CMD_MARGIN_LOW: rdata_d = mlow_q;
				`VLMS_CMD_SLEW_RATE: rdata_d = rate_q; // [RULE_15]
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Target selection and limit clamp
	// ------------------------------------------------------------------
	logic limit_drop;

	always_comb begin
		// Defaults are not in place before boot_q, so a zero limit must not clamp
		clamp_d = conv_en && over && boot_q; // [RULE_03] [RULE_05]
		target_d = clamp_d ? 26'(limit_abs) : 26'(cand_abs); // [RULE_03]
		// A clamped target that falls means the limit went below the target in effect
		limit_drop = clamp_q && target_d < target_q; // [RULE_05]
		// One warning per entry into the clamped state and per lowering of the limit
		warn_evt = clamp_d && (!clamp_q || limit_drop); // [RULE_04] [RULE_05]
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// Registers clear here, bar the rate exponent; defaults load on the first enabled edge after
			limit_q <= 16'h0000;
			mhigh_q <= 16'h0000;
			mlow_q <= 16'h0000;
			rate_q <= {`VLMS_SLEW_EXP_RST, 11'h000}; // [RULE_14]
			boot_q <= 1'b0;
			clamp_q <= 1'b0;
			ack_q <= 1'b0;
			nack_q <= 1'b0;
			rdata_q <= 16'h0000;
			target_q <= 26'h000_0000;
		end else if (ce) begin
			limit_q <= limit_d;
			mhigh_q <= mhigh_d;
			mlow_q <= mlow_d;
			rate_q <= rate_d;
			boot_q <= boot_d;
			clamp_q <= clamp_d;
			ack_q <= ack_d;
			nack_q <= nack_d;
			rdata_q <= rdata_d;
			target_q <= target_d;
		end
	end

	// ------------------------------------------------------------------
	// Slew engine
	// ------------------------------------------------------------------
	vlms_ramp_if rif();

	// The engine follows the registered target, one cycle behind the inputs
	assign rif.target = $signed(target_q);
	assign rif.step = step; // [RULE_09]
	// On/off ramps belong to the soft-start path, so the rate is skipped
	assign rif.bypass = onoff_ramp || !conv_en; // [RULE_13]

	vlms_ramp u_ramp (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.rif(rif)
	);

	// ------------------------------------------------------------------
	// Status and alert
	// ------------------------------------------------------------------
	logic [3:0] flags;

	// Three bits share the warning event so they can never disagree
	vlms_status #(
		.N(4)
	) u_status (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.set({invalid_evt, warn_evt, warn_evt, warn_evt}), // [RULE_04] [RULE_11]
		.clear(status_clear),
		.flags(flags),
		.alert_n(alert_n)
	);

	assign status_none_above = flags[0];
	assign status_word_vout = flags[1];
	assign status_vout_maxmin = flags[2];
	assign status_cml_invalid = flags[3];

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign cmd_ack = ack_q;
	assign cmd_nack = nack_q;
	assign cmd_rdata = rdata_q;
	assign target_abs = target_q;
	assign vref_abs = rif.vref;
	assign vref_settled = rif.settled;
endmodule

// ===== test/vlms_host_model.sv
// Host-side command master driving the register bank
`timescale 1ns/1ps
module vlms_host_model (
	input wire logic clk,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	input wire logic cmd_ack,
	input wire logic cmd_nack,
	input wire logic [15:0] cmd_rdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// One word per command pulse; released code and data lines are scrambled, not left stale
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
			output logic [1:0] resp, output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code <= code;
		cmd_wdata <= data;
		@(posedge clk);
		cmd_valid <= 1'b0;
		resp = 2'b00;
		rd = 16'h0000;
		// The answer stands one cycle; take it at the edge that ends it
		while (resp == 2'b00 && n < 4) begin
			@(posedge clk);
			resp = {cmd_nack, cmd_ack};
			rd = cmd_rdata;
			n++;
		end
		cmd_code <= ~code;
		cmd_wdata <= ~data;
	endtask
endmodule

// ===== test/vlms_top_asserts.sv
// Concurrent checks on the ports of the limit, margin and slew bank
`timescale 1ns/1ps
module vlms_top_asserts
	import vlms_pkg::*;
#(
	parameter vlms_abs_t VALID_MAX_ABS = 26'sd24576
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_ack,
	input wire logic cmd_nack,
	input wire logic [4:0] vout_exp,
	input wire logic vout_relative,
	input wire logic [15:0] trim_cmd,
	input wire logic conv_en,
	input wire logic onoff_ramp,
	input wire logic status_clear,
	input wire logic [25:0] target_abs,
	input wire logic [25:0] vref_abs,
	input wire logic status_none_above,
	input wire logic status_word_vout,
	input wire logic status_vout_maxmin,
	input wire logic status_cml_invalid,
	input wire logic alert_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic wr;
	logic mapped;
	logic normal;
	logic any_flag;
	assign wr = cmd_valid && cmd_write;
	assign mapped = cmd_code inside {[8'h24:8'h27]};
	assign normal = conv_en && !onoff_ramp;
	assign any_flag = status_none_above || status_word_vout || status_vout_maxmin
		|| status_cml_invalid;

	a_ack_mapped: assert property (cmd_valid && mapped |=> cmd_ack && !cmd_nack)
		else $error("mapped command not acknowledged");
	a_nack_unmapped: assert property (cmd_valid && !mapped |=> cmd_nack && !cmd_ack)
		else $error("unmapped command not refused");
	a_idle_quiet: assert property (!cmd_valid |=> !cmd_ack && !cmd_nack)
		else $error("answer without a command");
	a_rate_invalid: assert property (wr && cmd_code == 8'h27 && cmd_wdata[15:11] == 5'h1c
		&& (cmd_wdata[10:0] < 11'd2 || cmd_wdata[10:0] > 11'd254) |=> ##[0:1] status_cml_invalid)
		else $error("out of span rate accepted silently");
	a_margin_invalid: assert property (wr && cmd_code inside {8'h25, 8'h26}
		&& !vout_relative && vout_exp == 5'h14 && trim_cmd == 16'h0000
		&& $signed({10'h000, cmd_wdata}) > VALID_MAX_ABS |=> ##[0:1] status_cml_invalid)
		else $error("out of range margin accepted silently");
	a_warn_trio: assert property ($rose(status_vout_maxmin) |-> status_none_above
		&& status_word_vout)
		else $error("limit warning bits not set together");
	a_alert_follow: assert property (any_flag |-> !alert_n)
		else $error("alert not raised for a set flag");
	a_alert_quiet: assert property (!any_flag |-> alert_n)
		else $error("alert raised with no flag");
	a_flag_sticky: assert property (status_vout_maxmin && !status_clear |=> status_vout_maxmin)
		else $error("limit warning dropped without clear");
	a_ramp_slew: assert property (normal [*3] |-> vref_abs <= $past(vref_abs) + 26'd2
		&& $past(vref_abs) <= vref_abs + 26'd2)
		else $error("reference moved faster than the slew step");
	a_bypass_copy: assert property ((onoff_ramp && $stable(target_abs)) [*3]
		|=> vref_abs == $past(target_abs))
		else $error("on/off ramp did not bypass the slew");

	c_clamp: cover property ($rose(status_vout_maxmin));
	c_invalid: cover property ($rose(status_cml_invalid));
	c_nack: cover property (cmd_nack);
endmodule

bind vlms_top vlms_top_asserts #(.VALID_MAX_ABS(VALID_MAX_ABS)) i_chk (.clk(clk),
	.resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
	.cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .vout_exp(vout_exp),
	.vout_relative(vout_relative), .trim_cmd(trim_cmd), .conv_en(conv_en),
	.onoff_ramp(onoff_ramp), .status_clear(status_clear), .target_abs(target_abs),
	.vref_abs(vref_abs), .status_none_above(status_none_above),
	.status_word_vout(status_word_vout), .status_vout_maxmin(status_vout_maxmin),
	.status_cml_invalid(status_cml_invalid), .alert_n(alert_n));

// ===== test/tb.sv
// Self-checking bench for the limit, margin and slew register bank
`timescale 1ns/1ps
module tb;
	logic clk, resetn, conv_en, onoff_ramp, status_clear, restore_defaults, limit_from_pin;
	logic cmd_valid, cmd_write, cmd_ack, cmd_nack, vref_settled, alert_n, ce, vout_relative;
	logic s_none, s_word, s_max, s_inv;
	logic [1:0] margin_sel, resp;
	logic [4:0] vout_exp;
	logic [7:0] cmd_code;
	logic [15:0] trim_cmd, cmd_wdata, cmd_rdata, rd, nominal_cmd;
	logic [25:0] target_abs, vref_abs;
	// Register, value pairs: limit, margins, then two in-span rate words
	logic [7:0] codes [5] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h27};
	logic [15:0] vals [5] = '{16'h2000, 16'h1400, 16'h0c00, 16'hd87f, 16'he0fe};
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	vlms_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack),
		.cmd_rdata(cmd_rdata));

	vlms_top i_dut (.clk(clk), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack),
		.cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata), .vout_exp(vout_exp),
		.vout_relative(vout_relative),
		.nominal_cmd(nominal_cmd), .trim_cmd(trim_cmd), .margin_sel(margin_sel),
		.conv_en(conv_en), .onoff_ramp(onoff_ramp), .nvm_upper_limit(16'h3000),
		.pin_upper_limit(16'h2800), .limit_from_pin(limit_from_pin),
		.nvm_margin_high(16'h1200), .nvm_margin_low(16'h0e00), .nvm_slew_mantissa(11'h010),
		.restore_defaults(restore_defaults), .status_clear(status_clear),
		.target_abs(target_abs), .vref_abs(vref_abs), .vref_settled(vref_settled),
		.status_none_above(s_none), .status_word_vout(s_word), .status_vout_maxmin(s_max),
		.status_cml_invalid(s_inv), .alert_n(alert_n));

	task automatic check(input logic [25:0] got, input logic [25:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] code, input logic [15:0] d);
		i_host.xfer(1'b1, code, d, resp, rd);
		check(26'(resp), 26'h1);
	endtask

	task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
		i_host.xfer(1'b0, code, 16'h0000, resp, rd);
		check(26'(rd), 26'(exp));
	endtask

	task automatic clear_flags();
		@(posedge clk);
		status_clear <= 1'b1;
		@(posedge clk);
		status_clear <= 1'b0;
		waitc(2);
		check(26'({s_none, s_word, s_max, s_inv, alert_n}), 26'h1);
	endtask

	// Not in one step, then lands exactly within a bounded wait
	task automatic settle(input logic [25:0] exp);
		int n;
		n = 0;
		waitc(3);
		check(target_abs, exp);
		check(26'(vref_abs == exp), 26'h0);
		while (vref_settled !== 1'b1 && n < 5000) begin
			waitc(1);
			n++;
		end
		check(vref_abs, exp);
	endtask

	task automatic end_of_test();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	initial begin
		resetn = 1'b0;
		conv_en = 1'b1;
		onoff_ramp = 1'b1;
		status_clear = 1'b0;
		restore_defaults = 1'b0;
		limit_from_pin = 1'b0;
		margin_sel = 2'h0;
		trim_cmd = 16'h0000;
		ce = 1'b1;
		vout_exp = 5'h14;
		vout_relative = 1'b0;
		nominal_cmd = 16'h1000;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		waitc(3);
		rdchk(8'h24, 16'h3000);
		rdchk(8'h25, 16'h1200);
		rdchk(8'h26, 16'h0e00);
		rdchk(8'h27, 16'he010);
		i_host.xfer(1'b0, 8'h28, 16'h0000, resp, rd);
		check(26'({resp, rd}), 26'h2_0000);
		foreach (codes[k]) begin
			wr(codes[k], vals[k]);
			rdchk(codes[k], vals[k]);
		end
		wr(8'h27, 16'he001);
		wr(8'h27, 16'he0ff);
		rdchk(8'h27, 16'he0fe);
		check(26'({s_inv, alert_n}), 26'h2);
		clear_flags();
		@(posedge clk);
		ce <= 1'b0;
		onoff_ramp <= 1'b0;
		trim_cmd <= 16'h0100;
		margin_sel <= 2'h2;
		waitc(4);
		check(target_abs, 26'h1000);
		check(vref_abs, 26'h1000);
		@(posedge clk);
		ce <= 1'b1;
		settle(26'h1500);
		@(posedge clk);
		margin_sel <= 2'h1;
		settle(26'h0d00);
		wr(8'h25, 16'h2400);
		@(posedge clk);
		margin_sel <= 2'h2;
		settle(26'h2000);
		check(26'({s_none, s_word, s_max, alert_n}), 26'he);
		clear_flags();
		wr(8'h24, 16'h1800);
		waitc(3);
		check(target_abs, 26'h1800);
		check(26'({s_none, s_word, s_max}), 26'h7);
		clear_flags();
		@(posedge clk);
		trim_cmd <= 16'h0000;
		wr(8'h25, 16'h6001);
		rdchk(8'h25, 16'h2400);
		check(26'(s_inv), 26'h1);
		@(posedge clk);
		onoff_ramp <= 1'b1;
		conv_en <= 1'b0;
		waitc(5);
		check(target_abs, 26'h2400);
		check(vref_abs, 26'h2400);
		@(posedge clk);
		limit_from_pin <= 1'b1;
		restore_defaults <= 1'b1;
		@(posedge clk);
		restore_defaults <= 1'b0;
		rdchk(8'h24, 16'h2800);
		rdchk(8'h27, 16'he010);
		@(posedge clk);
		vout_relative <= 1'b1;
		nominal_cmd <= 16'h0800;
		waitc(3);
		check(target_abs, 26'h1a00);
		@(posedge clk);
		vout_exp <= 5'h1f;
		waitc(3);
		check(target_abs, 26'h1a_0000);
		end_of_test();
	end
endmodule
